/* File: verilog/sps_pkg.sv */
// Package for the socket present-state status block
// Assumes a 32-bit APB register bus on one clock
package sps_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0]  SPS_OFF_EVENT   = 8'h00;
   localparam logic [7:0]  SPS_OFF_PRESENT = 8'h08;
   localparam logic [7:0]  SPS_OFF_FORCE   = 8'h0c;
   localparam logic [7:0]  SPS_OFF_CTRL    = 8'h40;
   localparam logic [31:0] SPS_PRESENT_RST = 32'h3000_0000;
   localparam logic [31:0] SPS_ZERO        = 32'h0000_0000;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int SPS_B_SOCK_YY   = 31;
   localparam int SPS_B_SOCK_XX   = 30;
   localparam int SPS_B_SOCK_3V   = 29;
   localparam int SPS_B_SOCK_5V   = 28;
   localparam int SPS_B_CARD_HI   = 13;
   localparam int SPS_B_CARD_LO   = 10;
   localparam int SPS_B_BADREQ    = 9;
   localparam int SPS_B_DATALOSS  = 8;
   localparam int SPS_B_UNRECOG   = 7;
   localparam int SPS_B_READY     = 6;
   localparam int SPS_B_CARDBUS   = 5;
   localparam int SPS_B_SIXTEEN   = 4;
   localparam int SPS_B_POWERED   = 3;
   localparam int SPS_B_DET2      = 2;
   localparam int SPS_B_DET1      = 1;
   localparam int SPS_B_STSCHG    = 0;
   localparam int SPS_B_REINTERR  = 14;
   localparam int SPS_B_CTRL_PWR  = 0;
   localparam int SPS_B_CTRL_BADV = 1;
   localparam int SPS_B_CTRL_LOST = 2;
   localparam int SPS_EVENT_W     = 4;
   localparam int SPS_ID_CYCLES   = 16;
   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic       ready_irq;
      logic       status_change;
      logic       detect_two;
      logic       detect_one;
   } sps_pins_t;
   typedef struct packed {
      logic [3:0] volts;
      logic       unrecog;
      logic       cardbus;
      logic       sixteen;
   } sps_ident_t;
   typedef enum logic [2:0] {
      SPS_IDLE  = 3'b001,
      SPS_IDENT = 3'b010,
      SPS_DONE  = 3'b100
   } sps_state_t;
endpackage

/* File: verilog/sps_sync.sv */
// Three-stage synchroniser for asynchronous card-side levels
// Assumes pclk domain; output changes once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module sps_sync
   import sps_pkg::*;
#(
   parameter int W = 4
)(
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Levels
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end
      else
      begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               q[i] <= 1'b0;
            else if (s2_r[i] == s3_r[i])
               q[i] <= s3_r[i];
         end
      end
   endgenerate
endmodule // sps_sync
`default_nettype wire

/* File: verilog/sps_apb.sv */
// APB slave front end: decodes a word address, zero-wait answer
// Assumes APB3 master; unmapped addresses answer with pslverr
`timescale 1ns/1ns
`default_nettype none
module sps_apb
   import sps_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   output var  logic        pready,
   output var  logic        pslverr,
   // Decoded strobes
   output var  logic        wr_force,
   output var  logic        wr_ctrl,
   output var  logic        rd_hit
);
   logic access;
   logic mapped;
   assign access = psel && !penable;
   assign mapped = (paddr == SPS_OFF_PRESENT) || (paddr == SPS_OFF_FORCE) ||
                   (paddr == SPS_OFF_CTRL) || (paddr == SPS_OFF_EVENT);
   // Decision made in setup so the access phase answers from flops
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready   <= 1'b0;
         pslverr  <= 1'b0;
         wr_force <= 1'b0;
         wr_ctrl  <= 1'b0;
         rd_hit   <= 1'b0;
      end
      else
      begin
         pready   <= access;
         pslverr  <= access && !mapped;
         wr_force <= access && pwrite && (paddr == SPS_OFF_FORCE);
         wr_ctrl  <= access && pwrite && (paddr == SPS_OFF_CTRL);
         rd_hit   <= access && !pwrite;
      end
   end
endmodule // sps_apb
`default_nettype wire

/* File: verilog/sps_top.sv */
// Socket present-state status register with APB access
// Assumes card pins asynchronous; interrogation results come from the
// identification logic as a level plus a done strobe on pclk.
`timescale 1ns/1ns
`default_nettype none
module sps_top
   import sps_pkg::*;
#(
   parameter int ID_CYCLES = SPS_ID_CYCLES
)(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // Card pins, asynchronous
   input  wire logic        ready_irq_pin,
   input  wire logic        status_change_pin,
   input  wire logic        detect_two_n,
   input  wire logic        detect_one_n,
   // Identification results
   input  wire logic        ident_done,
   input  wire sps_ident_t  ident_result,
   // Status toward the controller
   output var  logic        identifying,
   output var  logic        ctrl_enable,
   output var  logic        status_change_event_flag
);
   // ****************************************
   // Bus front end
   // ****************************************
   logic       wr_force;
   logic       wr_ctrl;
   logic       rd_hit;
   logic [7:0] addr_r;
   sps_apb u_apb (
      .pclk     (pclk),
      .presetn  (presetn),
      .psel     (psel),
      .penable  (penable),
      .pwrite   (pwrite),
      .paddr    (paddr),
      .pready   (pready),
      .pslverr  (pslverr),
      .wr_force (wr_force),
      .wr_ctrl  (wr_ctrl),
      .rd_hit   (rd_hit)
   );
   logic [31:0] wdata_r;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         addr_r  <= '0;
         wdata_r <= '0;
      end
      else if (psel && !penable)
      begin
         addr_r  <= paddr;
         wdata_r <= pwdata;
      end
   end
   // ****************************************
   // Pin synchronisation
   // ****************************************
   sps_pins_t pins_raw;
   sps_pins_t pins_s;
   assign pins_raw = '{ready_irq:     ready_irq_pin,
                       status_change: status_change_pin,
                       detect_two:    detect_two_n,
                       detect_one:    detect_one_n};
   sps_sync #(.W(4)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (pins_raw),
      .q       (pins_s)
   );
   // ****************************************
   // Identification sequencing
   // ****************************************
   sps_state_t  state_r;
   logic [15:0] id_cnt_r;
   logic        both_in;
   logic        both_in_q_r;
   logic        insert_evt;
   logic        reinterr;
   logic        id_timeout;
   assign both_in    = !pins_s.detect_one && !pins_s.detect_two;
   assign insert_evt = both_in && !both_in_q_r;
   assign reinterr   = wr_force && wdata_r[SPS_B_REINTERR];
   assign id_timeout = (id_cnt_r == 16'(ID_CYCLES - 1));
   always_ff @(posedge pclk or negedge presetn)
   begin
      // Starts high: the synchroniser resets low, which must not look like an insertion
      if (!presetn)
         both_in_q_r <= 1'b1;
      else if (state_r != SPS_IDENT)
         both_in_q_r <= both_in;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_r <= SPS_IDLE;
      else
      begin
         case (state_r)
            SPS_IDLE, SPS_DONE:
               if (insert_evt || reinterr)
                  state_r <= SPS_IDENT;
            SPS_IDENT:
               if (ident_done || id_timeout)
                  state_r <= SPS_DONE;
            default:
               state_r <= SPS_IDLE;
         endcase
      end
   end
   // Timeout keeps a silent identifier from freezing detect bits forever
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         id_cnt_r <= '0;
      else if (state_r == SPS_IDENT)
         id_cnt_r <= id_cnt_r + 16'h0001;
      else
         id_cnt_r <= '0;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         identifying <= 1'b0;
      else
         identifying <= (state_r == SPS_IDENT);
   end
   // ****************************************
   // Present-state fields
   // ****************************************
   logic [3:0] sock_cap_r;
   logic [3:0] card_volts_r;
   logic       unrecog_r;
   logic       cardbus_r;
   logic       sixteen_r;
   logic       badreq_r;
   logic       dataloss_r;
   logic       powered_r;
   logic       det_one_r;
   logic       det_two_r;
   logic       ident_take;
   assign ident_take = (state_r == SPS_IDENT) && ident_done;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sock_cap_r <= SPS_PRESENT_RST[SPS_B_SOCK_YY:SPS_B_SOCK_5V];
      else if (wr_force)
         sock_cap_r <= wdata_r[SPS_B_SOCK_YY:SPS_B_SOCK_5V];
   end
   // Latched only at the end of an identification or by force
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         card_volts_r <= '0;
         cardbus_r    <= 1'b0;
         sixteen_r    <= 1'b0;
         unrecog_r    <= 1'b0;
      end
      else if (ident_take)
      begin
         card_volts_r <= ident_result.volts;
         cardbus_r    <= ident_result.cardbus;
         sixteen_r    <= ident_result.sixteen;
         unrecog_r    <= ident_result.unrecog;
      end
      else if (wr_force)
      begin
         card_volts_r <= wdata_r[SPS_B_CARD_HI:SPS_B_CARD_LO];
         cardbus_r    <= wdata_r[SPS_B_CARDBUS];
         sixteen_r    <= wdata_r[SPS_B_SIXTEEN];
         unrecog_r    <= wdata_r[SPS_B_UNRECOG];
      end
   end
   // Condition inputs from the controller arrive via the control word
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         badreq_r   <= 1'b0;
         dataloss_r <= 1'b0;
         powered_r  <= 1'b0;
      end
      else if (wr_force)
      begin
         badreq_r   <= wdata_r[SPS_B_BADREQ];
         dataloss_r <= wdata_r[SPS_B_DATALOSS];
      end
      else if (wr_ctrl)
      begin
         badreq_r   <= badreq_r | wdata_r[SPS_B_CTRL_BADV];
         dataloss_r <= dataloss_r | wdata_r[SPS_B_CTRL_LOST];
         powered_r  <= wdata_r[SPS_B_CTRL_PWR];
      end
   end
   // Detect bits freeze while identification drives the detect lines
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         det_one_r <= 1'b1;
         det_two_r <= 1'b1;
      end
      else if (state_r != SPS_IDENT)
      begin
         det_one_r <= pins_s.detect_one;
         det_two_r <= pins_s.detect_two;
      end
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_enable <= 1'b1;
      else if (reinterr)
         ctrl_enable <= 1'b1;
      else if (wr_force && (wdata_r[SPS_B_CARD_HI:SPS_B_CARD_LO] != 4'h0))
         ctrl_enable <= 1'b0;
   end
   // ****************************************
   // Status-change event
   // ****************************************
   logic sts_q_r;
   logic sts_evt;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sts_q_r <= 1'b0;
      else
         sts_q_r <= pins_s.status_change;
   end
   assign sts_evt = cardbus_r ? (pins_s.status_change && !sts_q_r)
                              : (pins_s.status_change != sts_q_r);
   // Event register write-one-to-clear; a new event wins over the clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         status_change_event_flag <= 1'b0;
      else if (sts_evt || (wr_force && wdata_r[SPS_B_STSCHG]))
         status_change_event_flag <= 1'b1;
      else if (pready && pwrite && addr_r == SPS_OFF_EVENT && wdata_r[SPS_B_STSCHG])
         status_change_event_flag <= 1'b0;
   end
   // ****************************************
   // Readback
   // ****************************************
   logic [31:0] present_word;
   always_comb
   begin
      present_word = SPS_ZERO;
      present_word[SPS_B_SOCK_YY:SPS_B_SOCK_5V]  = sock_cap_r;
      present_word[SPS_B_CARD_HI:SPS_B_CARD_LO]  = card_volts_r;
      present_word[SPS_B_BADREQ]   = badreq_r;
      present_word[SPS_B_DATALOSS] = dataloss_r;
      present_word[SPS_B_UNRECOG]  = unrecog_r;
      present_word[SPS_B_READY]    = pins_s.ready_irq;
      present_word[SPS_B_CARDBUS]  = cardbus_r;
      present_word[SPS_B_SIXTEEN]  = sixteen_r;
      present_word[SPS_B_POWERED]  = powered_r;
      present_word[SPS_B_DET2]     = det_two_r;
      present_word[SPS_B_DET1]     = det_one_r;
      present_word[SPS_B_STSCHG]   = pins_s.status_change;
   end
   // Present state ignores writes to its own offset; only force and control writes change its fields
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= '0;
      else if (psel && !penable && !pwrite)
      begin
         case (paddr)
            SPS_OFF_PRESENT: prdata <= present_word;
            SPS_OFF_EVENT:   prdata <= {31'h0, status_change_event_flag};
            SPS_OFF_CTRL:    prdata <= {31'h0, powered_r};
            default:         prdata <= SPS_ZERO;
         endcase
      end
   end
   // ****************************************
   // Checks
   // ****************************************
   reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_hit && addr_r == SPS_OFF_PRESENT) |-> prdata[27:14] == 14'h0)
      else $error("reserved bits nonzero");
   sock_cap_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(wr_force) && $past(presetn) |-> sock_cap_r == $past(sock_cap_r))
      else $error("socket capability changed without force");
   force_visible_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_force && !ident_take |=> card_volts_r == $past(wdata_r[13:10]))
      else $error("forced card volts not reflected");
   type_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ident_take && !wr_force |=> $stable(cardbus_r) && $stable(sixteen_r))
      else $error("card type changed outside interrogation");
   detect_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == SPS_IDENT |=> $stable(det_one_r) && $stable(det_two_r))
      else $error("detect bits moved during identification");
   cb_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
      cardbus_r && $rose(pins_s.status_change) |=> status_change_event_flag)
      else $error("rising status change missed");
   reint_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      reinterr && state_r != SPS_IDENT |=> state_r == SPS_IDENT ##1 identifying)
      else $error("reinterrogation did not start");
   sts_mirror_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_hit && addr_r == SPS_OFF_PRESENT) |-> prdata[0] == $past(pins_s.status_change))
      else $error("status change level wrong");
   ident_cov: cover property (@(posedge pclk) disable iff (!presetn)
      state_r == SPS_IDENT ##[1:20] state_r == SPS_DONE);
   force_cov: cover property (@(posedge pclk) disable iff (!presetn) wr_force);
   event_cov: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(status_change_event_flag));
endmodule // sps_top
`default_nettype wire

/* File: test/sps_card_model.sv */
// Behavioural model of the card socket and the identification logic
// Assumes the bench calls its tasks from the pclk domain
`timescale 1ns/1ns
`default_nettype none
module sps_card_model
   import sps_pkg::*;
(
   // Clock
   input  wire logic       pclk,
   // From the block
   input  wire logic       identifying,
   // Card pins
   output var  logic       ready_irq_pin,
   output var  logic       status_change_pin,
   output var  logic       detect_two_n,
   output var  logic       detect_one_n,
   // Identification results
   output var  logic       ident_done,
   output var  sps_ident_t ident_result
);
   sps_ident_t last_r;
   // Detect lines idle high through the socket pull-ups
   initial
   begin
      ready_irq_pin     = 1'b0;
      status_change_pin = 1'b0;
      detect_two_n      = 1'b1;
      detect_one_n      = 1'b1;
      ident_done        = 1'b0;
      last_r            = '0;
   end
   // Result is only valid with the strobe, junk otherwise
   assign ident_result = ident_done ? last_r : ~last_r;
   task automatic set_pins(input logic rdy, input logic sts);
      @(posedge pclk);
      ready_irq_pin     <= rdy;
      status_change_pin <= sts;
   endtask
   task automatic set_detect(input logic two, input logic one);
      @(posedge pclk);
      detect_two_n <= two;
      detect_one_n <= one;
   endtask
   // Bounded so a dead block cannot hang the model
   task automatic wait_ident(output logic seen);
      int n;
      n = 0;
      while (identifying !== 1'b1 && n < 50)
      begin
         @(posedge pclk);
         n++;
      end
      seen = identifying;
   endtask
   task automatic pulse(input sps_ident_t res);
      @(posedge pclk);
      ident_done <= 1'b1;
      last_r     <= res;
      @(posedge pclk);
      ident_done <= 1'b0;
   endtask
endmodule // sps_card_model
`default_nettype wire

/* File: test/socket_present_state_status_tb.sv */
// Self-checking bench for the socket present-state status block
// Assumes the card model answers identification; APB master below
`timescale 1ns/1ns
`default_nettype none
module socket_present_state_status_tb
   import sps_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, cur;
   logic        pready, pslverr, ident_done, identifying, ctrl_enable, flag;
   logic        rdy, sts, det2, det1, seen;
   sps_ident_t  res;
   sps_ident_t  tab [3] = '{7'h1a, 7'h0d, 7'h61};
   int          n_mismatch, compares;
   initial pclk = 1'b0;
   always #2 pclk = ~pclk;
   sps_top #(.ID_CYCLES(64)) u_sps_top (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ready_irq_pin(rdy), .status_change_pin(sts), .detect_two_n(det2),
      .detect_one_n(det1), .ident_done(ident_done), .ident_result(res),
      .identifying(identifying), .ctrl_enable(ctrl_enable),
      .status_change_event_flag(flag));
   sps_card_model u_sps_card_model (.pclk(pclk), .identifying(identifying),
      .ready_irq_pin(rdy), .status_change_pin(sts), .detect_two_n(det2),
      .detect_one_n(det1), .ident_done(ident_done), .ident_result(res));
   // ********
   // Tasks
   // ********
   task automatic wrap_up();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp);
      compares++;
      if (seen_v !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen_v, exp);
      end
   endtask
   // Request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // No cycle budget here; only the watchdog ends a stuck wait
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
      logic [31:0] d;
      logic        e;
      apb(1'b0, a, '0, d, e);
      chk(d, exp);
      chk(e, experr);
   endtask
   // Insertion with a detect bounce while the card is identified
   task automatic insertion(input sps_ident_t r);
      u_sps_card_model.set_detect(1'b1, 1'b1);
      repeat (8) @(posedge pclk);
      u_sps_card_model.set_detect(1'b0, 1'b0);
      u_sps_card_model.wait_ident(seen);
      chk(seen, 1'b1);
      u_sps_card_model.set_detect(1'b0, 1'b1);
      repeat (6) @(posedge pclk);
      rd_chk(SPS_OFF_PRESENT, cur, 1'b0);
      u_sps_card_model.set_detect(1'b0, 1'b0);
      // Detect lines must be through the synchroniser before identification ends
      repeat (4) @(posedge pclk);
      u_sps_card_model.pulse(r);
      cur = SPS_PRESENT_RST | (32'(r.volts) << 10) | (32'(r.unrecog) << 7)
            | (32'(r.cardbus) << 5) | (32'(r.sixteen) << 4);
      repeat (6) @(posedge pclk);
      rd_chk(SPS_OFF_PRESENT, cur, 1'b0);
      u_sps_card_model.pulse(~r);
      repeat (4) @(posedge pclk);
      rd_chk(SPS_OFF_PRESENT, cur, 1'b0);
      u_sps_card_model.set_pins(1'b0, 1'b1);
      repeat (6) @(posedge pclk);
      chk(flag, 1'b1);
      rd_chk(SPS_OFF_PRESENT, cur | 32'h1, 1'b0);
      wr(SPS_OFF_EVENT, 32'h1);
      u_sps_card_model.set_pins(1'b0, 1'b0);
      repeat (6) @(posedge pclk);
      chk(flag, r.sixteen);
      wr(SPS_OFF_EVENT, 32'h1);
   endtask
   // ********
   // Tests
   // ********
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      n_mismatch = 0;
      compares = 0;
      cur = SPS_PRESENT_RST;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      chk({identifying, ctrl_enable}, 2'b01);
      rd_chk(SPS_OFF_PRESENT, 32'h3000_0006, 1'b0);
      u_sps_card_model.set_pins(1'b1, 1'b1);
      repeat (6) @(posedge pclk);
      rd_chk(SPS_OFF_PRESENT, 32'h3000_0047, 1'b0);
      u_sps_card_model.set_pins(1'b0, 1'b0);
      repeat (6) @(posedge pclk);
      wr(SPS_OFF_PRESENT, 32'hffff_ffff);
      rd_chk(SPS_OFF_PRESENT, 32'h3000_0006, 1'b0);
      rd_chk(8'h20, SPS_ZERO, 1'b1);
      wr(SPS_OFF_EVENT, 32'h1);
      for (int i = 0; i < 3; i++)
         insertion(tab[i]);
      wr(SPS_OFF_CTRL, 32'h7);
      rd_chk(SPS_OFF_PRESENT, cur | 32'h308, 1'b0);
      wr(SPS_OFF_CTRL, 32'h0);
      rd_chk(SPS_OFF_PRESENT, cur | 32'h300, 1'b0);
      wr(SPS_OFF_FORCE, 32'hc000_2380);
      rd_chk(SPS_OFF_PRESENT, 32'hc000_2380, 1'b0);
      chk(ctrl_enable, 1'b0);
      wr(SPS_OFF_FORCE, 32'h3000_4000);
      u_sps_card_model.wait_ident(seen);
      chk(seen, 1'b1);
      u_sps_card_model.pulse(tab[0]);
      repeat (6) @(posedge pclk);
      chk(ctrl_enable, 1'b1);
      rd_chk(SPS_OFF_PRESENT, 32'h3000_0c20, 1'b0);
      wrap_up();
   end
   // Whole run is a few hundred cycles; this is far beyond it
   initial
   begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      wrap_up();
   end
endmodule // socket_present_state_status_tb
`default_nettype wire
